// ---- hw/rccfg_pkg.sv ----
package rccfg_pkg;
  // Register offsets
  localparam logic [7:0] RCCFG_OFS_FILTER_DUTY  = 8'h10;
  localparam logic [7:0] RCCFG_OFS_RIPPLE_CTRL  = 8'h11;
  localparam logic [7:0] RCCFG_OFS_THR_LOW      = 8'h12;
  localparam logic [7:0] RCCFG_OFS_SCALE_CTRL   = 8'h13;
  localparam logic [7:0] RCCFG_OFS_INV_RES      = 8'h14;
  localparam logic [7:0] RCCFG_OFS_BACKEMF      = 8'h15;
  // Reset values
  localparam logic [7:0] RCCFG_RST_FILTER_DUTY  = 8'h00;
  localparam logic [7:0] RCCFG_RST_RIPPLE_CTRL  = 8'h88;
  localparam logic [7:0] RCCFG_RST_THR_LOW      = 8'hff;
  localparam logic [7:0] RCCFG_RST_SCALE_CTRL   = 8'h7f;
  localparam logic [7:0] RCCFG_RST_INV_RES      = 8'h00;
  localparam logic [7:0] RCCFG_RST_BACKEMF      = 8'h00;
  // Field positions
  localparam int RCCFG_CUTOFF_LSB     = 6;
  localparam int RCCFG_DUTY_LSB       = 0;
  localparam int RCCFG_RIPPLE_EN_BIT  = 7;
  localparam int RCCFG_MODULE_OFF_BIT = 6;
  localparam int RCCFG_HIZ_BIT        = 5;
  localparam int RCCFG_FGAIN_LSB      = 3;
  localparam int RCCFG_MIRROR_LSB     = 0;
  localparam int RCCFG_INVR_MUL_LSB   = 6;
  localparam int RCCFG_BEMF_MUL_LSB   = 4;
  localparam int RCCFG_THR_MUL_LSB    = 2;
  localparam int RCCFG_THR_HI_LSB     = 0;
  // Cut-off frequencies in Hz
  localparam logic [9:0] RCCFG_CUTOFF_HZ0 = 10'd250;
  localparam logic [9:0] RCCFG_CUTOFF_HZ1 = 10'd500;
  localparam logic [9:0] RCCFG_CUTOFF_HZ2 = 10'd750;
  localparam logic [9:0] RCCFG_CUTOFF_HZ3 = 10'd1000;
  // Multiplier exponents (log2 of factor; back-EMF factor is RCCFG_BEMF_BASE shifted by it)
  localparam logic [3:0] RCCFG_THR_SH0 = 4'd1;
  localparam logic [3:0] RCCFG_THR_SH1 = 4'd3;
  localparam logic [3:0] RCCFG_THR_SH2 = 4'd4;
  localparam logic [3:0] RCCFG_THR_SH3 = 4'd6;
  localparam logic [3:0] RCCFG_INVR_SH0 = 4'd1;
  localparam logic [3:0] RCCFG_INVR_SH1 = 4'd6;
  localparam logic [3:0] RCCFG_INVR_SH2 = 4'd10;
  localparam logic [3:0] RCCFG_INVR_SH3 = 4'd13;
  localparam logic [3:0] RCCFG_BEMF_SH0 = 4'd8;
  localparam logic [3:0] RCCFG_BEMF_SH1 = 4'd9;
  localparam logic [3:0] RCCFG_BEMF_SH2 = 4'd12;
  localparam logic [3:0] RCCFG_BEMF_SH3 = 4'd13;
  localparam logic [4:0] RCCFG_BEMF_BASE = 5'd24;
  // Mirror gain encoded as log2(gain) + 3, so 4 A -> 5, 0.125 A -> 0
  localparam logic [2:0] RCCFG_MIRROR_G4   = 3'd5;
  localparam logic [2:0] RCCFG_MIRROR_G2   = 3'd4;
  localparam logic [2:0] RCCFG_MIRROR_G1   = 3'd3;
  localparam logic [2:0] RCCFG_MIRROR_G05  = 3'd2;
  localparam logic [2:0] RCCFG_MIRROR_G025 = 3'd1;
  localparam logic [2:0] RCCFG_MIRROR_G0125 = 3'd0;
  // Regulation mode codes seen on the mode input
  localparam logic [1:0] RCCFG_MODE_SPEED   = 2'b10;
  localparam logic [1:0] RCCFG_MODE_VOLTAGE = 2'b11;
  localparam logic [1:0] RCCFG_MODE_FIXED   = 2'b00;
endpackage

// ---- hw/rccfg_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
module rccfg_regs
  import rccfg_pkg::*;
#(
  parameter int COUNT_W = 17
) (
  input  wire logic               clk_sys_i,
  input  wire logic               sys_rst_i,
  input  wire logic               clk_en_i,
  input  wire logic [7:0]         reg_addr_i,
  input  wire logic               reg_wr_i,
  input  wire logic               reg_rd_i,
  input  wire logic [7:0]         reg_wdata_i,
  input  wire logic               bridge_ctrl_select_i,
  input  wire logic               duty_ctrl_select_i,
  input  wire logic [1:0]         reg_mode_i,
  input  wire logic               correction_pulse_off_i,
  input  wire logic [COUNT_W-1:0] ripple_count_value_i,
  output logic [7:0]              reg_rdata_o,
  output logic                    reg_rvalid_o,
  output logic [9:0]              output_filter_cutoff_o,
  output logic                    external_duty_active_o,
  output logic [5:0]              external_duty_value_o,
  output logic                    speed_reg_active_o,
  output logic                    voltage_reg_active_o,
  output logic                    ripple_enable_o,
  output logic                    correction_module_on_o,
  output logic                    correction_pulse_on_o,
  output logic                    bridge_hiz_o,
  output logic                    threshold_reached_o,
  output logic [4:0]              filter_input_gain_o,
  output logic [2:0]              current_mirror_gain_o,
  output logic [16:0]             ripple_threshold_eff_o,
  output logic [13:0]             inverse_resistance_multiplier_o,
  output logic [17:0]             backemf_multiplier_o,
  output logic [7:0]              inverse_resistance_value_o,
  output logic [7:0]              backemf_value_o
);

  // Threshold times 64 needs 16 bits plus one of headroom
  if (COUNT_W < 1 || COUNT_W > 17) begin : g_count_w_bad
    $error("COUNT_W must be between 1 and 17");
  end
  // The largest shift of each multiplier must fit its output port
  if (10 + int'(RCCFG_THR_SH3) > 17) begin : g_thr_sh_bad
    $error("threshold shift overflows the effective threshold");
  end
  if (int'(RCCFG_INVR_SH3) > 13) begin : g_invr_sh_bad
    $error("resistance shift overflows its multiplier output");
  end
  if (5 + int'(RCCFG_BEMF_SH3) > 18) begin : g_bemf_sh_bad
    $error("back-EMF shift overflows its multiplier output");
  end

  typedef struct packed {
    // Stored register bytes
    logic [7:0]  filter_duty;
    logic [7:0]  ripple_ctrl;
    logic [7:0]  thr_low;
    logic [7:0]  scale_ctrl;
    logic [7:0]  inv_res;
    logic [7:0]  backemf;
    // Read port
    logic [7:0]  rdata;
    logic        rvalid;
    // Decoded outputs, one flop each
    logic [9:0]  cutoff;
    logic        duty_act;
    logic [5:0]  duty;
    logic        speed_act;
    logic        volt_act;
    logic        rip_en;
    logic        mod_on;
    logic        pulse_on;
    logic        hiz;
    logic        reached;
    logic [4:0]  fgain;
    logic [2:0]  mirror;
    logic [16:0] thr_eff;
    logic [13:0] invr_mul;
    logic [17:0] bemf_mul;
  } rccfg_state_s;

  rccfg_state_s st;
  rccfg_state_s next_st;

  logic [9:0]  thr10;
  logic [3:0]  thr_sh;
  logic [3:0]  invr_sh;
  logic [3:0]  bemf_sh;
  logic [16:0] thr_calc;
  logic [16:0] count_ext;
  logic        external_duty_value;

  // Field views of the stored bytes
  logic [1:0]  cutoff_code;
  logic [5:0]  duty_code;
  logic        rip_en_bit;
  logic        mod_off_bit;
  logic        hiz_bit;
  logic [1:0]  fgain_code;
  logic [2:0]  mirror_code;
  logic [1:0]  thr_hi;
  logic [1:0]  thr_code;
  logic [1:0]  invr_code;
  logic [1:0]  bemf_code;
  logic        count_over;

  always_comb begin
    next_st = st;
    thr10 = '0;
    thr_sh = '0;
    invr_sh = '0;
    bemf_sh = '0;
    thr_calc = '0;
    count_ext = '0;
    external_duty_value = 1'b0;
    cutoff_code = '0;
    duty_code = '0;
    rip_en_bit = 1'b0;
    mod_off_bit = 1'b0;
    hiz_bit = 1'b0;
    fgain_code = '0;
    mirror_code = '0;
    thr_hi = '0;
    thr_code = '0;
    invr_code = '0;
    bemf_code = '0;
    count_over = 1'b0;
    next_st.rvalid = 1'b0;
    // Writes land in stored bytes, reads return them unchanged
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        RCCFG_OFS_FILTER_DUTY: next_st.filter_duty = reg_wdata_i;
        RCCFG_OFS_RIPPLE_CTRL: next_st.ripple_ctrl = reg_wdata_i;
        RCCFG_OFS_THR_LOW:     next_st.thr_low = reg_wdata_i;
        RCCFG_OFS_SCALE_CTRL:  next_st.scale_ctrl = reg_wdata_i;
        RCCFG_OFS_INV_RES:     next_st.inv_res = reg_wdata_i;
        RCCFG_OFS_BACKEMF:     next_st.backemf = reg_wdata_i;
        // Unmapped offsets are reserved, so writes there are dropped
        default: ;
      endcase
    end
    if (reg_rd_i) begin
      next_st.rvalid = 1'b1;
      unique case (reg_addr_i)
        RCCFG_OFS_FILTER_DUTY: next_st.rdata = st.filter_duty;
        RCCFG_OFS_RIPPLE_CTRL: next_st.rdata = st.ripple_ctrl;
        RCCFG_OFS_THR_LOW:     next_st.rdata = st.thr_low;
        RCCFG_OFS_SCALE_CTRL:  next_st.rdata = st.scale_ctrl;
        RCCFG_OFS_INV_RES:     next_st.rdata = st.inv_res;
        RCCFG_OFS_BACKEMF:     next_st.rdata = st.backemf;
        default:               next_st.rdata = 8'h00;
      endcase
    end

    // Field views of the stored bytes
    cutoff_code = st.filter_duty[RCCFG_CUTOFF_LSB +: 2];
    duty_code   = st.filter_duty[RCCFG_DUTY_LSB +: 6];
    rip_en_bit  = st.ripple_ctrl[RCCFG_RIPPLE_EN_BIT];
    mod_off_bit = st.ripple_ctrl[RCCFG_MODULE_OFF_BIT];
    hiz_bit     = st.ripple_ctrl[RCCFG_HIZ_BIT];
    fgain_code  = st.ripple_ctrl[RCCFG_FGAIN_LSB +: 2];
    mirror_code = st.ripple_ctrl[RCCFG_MIRROR_LSB +: 3];
    thr_hi      = st.scale_ctrl[RCCFG_THR_HI_LSB +: 2];
    thr_code    = st.scale_ctrl[RCCFG_THR_MUL_LSB +: 2];
    invr_code   = st.scale_ctrl[RCCFG_INVR_MUL_LSB +: 2];
    bemf_code   = st.scale_ctrl[RCCFG_BEMF_MUL_LSB +: 2];

    // Decode from stored bytes, so outputs lag a write by one cycle
    unique case (cutoff_code)
      2'b00: next_st.cutoff = RCCFG_CUTOFF_HZ0;
      2'b01: next_st.cutoff = RCCFG_CUTOFF_HZ1;
      2'b10: next_st.cutoff = RCCFG_CUTOFF_HZ2;
      2'b11: next_st.cutoff = RCCFG_CUTOFF_HZ3;
    endcase

    // Pin control plus duty select; register bridge control wins
    external_duty_value = !bridge_ctrl_select_i && duty_ctrl_select_i;
    next_st.duty_act = external_duty_value;
    // Duty code passes straight through: 0 is 0%, all ones is 100%
    next_st.duty = external_duty_value ? duty_code
                            : 6'h00;
    next_st.speed_act = !external_duty_value
                        && reg_mode_i == RCCFG_MODE_SPEED;
    next_st.volt_act  = !external_duty_value
                        && reg_mode_i == RCCFG_MODE_VOLTAGE;

    next_st.rip_en   = rip_en_bit;
    next_st.mod_on   = !mod_off_bit;
    // Pulse gating only matters while the module itself is on
    next_st.pulse_on = !mod_off_bit && !correction_pulse_off_i;

    unique case (fgain_code)
      2'b00: next_st.fgain = 5'd2;
      2'b01: next_st.fgain = 5'd4;
      2'b10: next_st.fgain = 5'd8;
      2'b11: next_st.fgain = 5'd16;
    endcase

    // Bit 1 is a don't-care once bit 2 is set
    if (mirror_code[2]) begin
      next_st.mirror = mirror_code[0]
                       ? RCCFG_MIRROR_G0125 : RCCFG_MIRROR_G025;
    end else begin
      unique case (mirror_code[1:0])
        2'b00: next_st.mirror = RCCFG_MIRROR_G4;
        2'b01: next_st.mirror = RCCFG_MIRROR_G2;
        2'b10: next_st.mirror = RCCFG_MIRROR_G1;
        2'b11: next_st.mirror = RCCFG_MIRROR_G05;
      endcase
    end

    thr10 = {thr_hi, st.thr_low};
    unique case (thr_code)
      2'b00: thr_sh = RCCFG_THR_SH0;
      2'b01: thr_sh = RCCFG_THR_SH1;
      2'b10: thr_sh = RCCFG_THR_SH2;
      2'b11: thr_sh = RCCFG_THR_SH3;
    endcase
    thr_calc = 17'({7'h00, thr10} << thr_sh);
    next_st.thr_eff = thr_calc;

    unique case (invr_code)
      2'b00: invr_sh = RCCFG_INVR_SH0;
      2'b01: invr_sh = RCCFG_INVR_SH1;
      2'b10: invr_sh = RCCFG_INVR_SH2;
      2'b11: invr_sh = RCCFG_INVR_SH3;
    endcase
    next_st.invr_mul = 14'(14'h0001 << invr_sh);

    unique case (bemf_code)
      2'b00: bemf_sh = RCCFG_BEMF_SH0;
      2'b01: bemf_sh = RCCFG_BEMF_SH1;
      2'b10: bemf_sh = RCCFG_BEMF_SH2;
      2'b11: bemf_sh = RCCFG_BEMF_SH3;
    endcase
    next_st.bemf_mul = 18'({13'h0000, RCCFG_BEMF_BASE} << bemf_sh);

    // Compare against the registered threshold so both bytes act together
    count_ext = 17'(ripple_count_value_i);
    // Strict greater: a count equal to the threshold does not trip
    count_over = st.rip_en && (count_ext > st.thr_eff);
    next_st.reached = count_over;
    next_st.hiz = hiz_bit && count_over;
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      st <= '0;
      st.filter_duty <= RCCFG_RST_FILTER_DUTY;
      st.ripple_ctrl <= RCCFG_RST_RIPPLE_CTRL;
      st.thr_low     <= RCCFG_RST_THR_LOW;
      st.scale_ctrl  <= RCCFG_RST_SCALE_CTRL;
      st.inv_res     <= RCCFG_RST_INV_RES;
      st.backemf     <= RCCFG_RST_BACKEMF;
    end else if (clk_en_i) begin
      st <= next_st;
    end
  end

  // Ports are straight copies of flops, so none of them can glitch
  assign reg_rdata_o                     = st.rdata;
  assign reg_rvalid_o                    = st.rvalid;
  assign output_filter_cutoff_o          = st.cutoff;
  assign external_duty_active_o          = st.duty_act;
  assign external_duty_value_o           = st.duty;
  assign speed_reg_active_o              = st.speed_act;
  assign voltage_reg_active_o            = st.volt_act;
  assign ripple_enable_o                 = st.rip_en;
  assign correction_module_on_o          = st.mod_on;
  assign correction_pulse_on_o           = st.pulse_on;
  assign bridge_hiz_o                    = st.hiz;
  assign threshold_reached_o             = st.reached;
  assign filter_input_gain_o             = st.fgain;
  assign current_mirror_gain_o           = st.mirror;
  assign ripple_threshold_eff_o          = st.thr_eff;
  assign inverse_resistance_multiplier_o = st.invr_mul;
  assign backemf_multiplier_o            = st.bemf_mul;
  assign inverse_resistance_value_o      = st.inv_res;
  assign backemf_value_o                 = st.backemf;

endmodule
`default_nettype wire

// ---- tb/rccfg_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module rccfg_props
  import rccfg_pkg::*;
#(parameter int COUNT_W = 17) (
  input wire logic               clk_sys_i,
  input wire logic               sys_rst_i,
  input wire logic               clk_en_i,
  input wire logic [7:0]         reg_addr_i,
  input wire logic               reg_wr_i,
  input wire logic               reg_rd_i,
  input wire logic [7:0]         reg_wdata_i,
  input wire logic               correction_pulse_off_i,
  input wire logic [COUNT_W-1:0] ripple_count_value_i,
  input wire logic               reg_rvalid_o,
  input wire logic [9:0]         output_filter_cutoff_o,
  input wire logic               external_duty_active_o,
  input wire logic [5:0]         external_duty_value_o,
  input wire logic               speed_reg_active_o,
  input wire logic               voltage_reg_active_o,
  input wire logic               ripple_enable_o,
  input wire logic               correction_module_on_o,
  input wire logic               correction_pulse_on_o,
  input wire logic               bridge_hiz_o,
  input wire logic               threshold_reached_o,
  input wire logic [16:0]        ripple_threshold_eff_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  sequence rd_req;
    clk_en_i && reg_rd_i;
  endsequence
  sequence wr_ctl;
    clk_en_i && reg_wr_i && reg_addr_i == RCCFG_OFS_RIPPLE_CTRL;
  endsequence
  // Threshold and enable must be settled, else the compare sees a mix
  sequence calm;
    clk_en_i && ripple_enable_o && $stable(ripple_threshold_eff_o);
  endsequence
  rd_answer_a: assert property (rd_req |=> reg_rvalid_o)
    else $error("read strobe drew no valid");
  en_decode_a: assert property (wr_ctl ##1 clk_en_i |=>
    ripple_enable_o == $past(reg_wdata_i[7], 2)) else $error("enable lost");
  ec_decode_a: assert property (wr_ctl ##1 clk_en_i |=>
    correction_module_on_o == !$past(reg_wdata_i[6], 2))
    else $error("correction bit lost");
  pulse_gate_a: assert property (correction_pulse_on_o |->
    !$past(correction_pulse_off_i)) else $error("pulse kept on");
  duty_excl_a: assert property (
    external_duty_active_o && $past(external_duty_active_o) |->
    !speed_reg_active_o && !voltage_reg_active_o) else $error("mode kept");
  duty_zero_a: assert property (
    !external_duty_active_o && !$past(external_duty_active_o) |->
    external_duty_value_o == 6'h00) else $error("duty leaks");
  hiz_cause_a: assert property (bridge_hiz_o |-> threshold_reached_o)
    else $error("hiz without threshold");
  thr_cmp_a: assert property (
    !$past(sys_rst_i, 2) ##0 calm ##1 calm |->
    threshold_reached_o == ($past(ripple_count_value_i) >
    $past(ripple_threshold_eff_o))) else $error("compare wrong");
  cutoff_set_a: assert property (!$past(sys_rst_i, 2) |->
    output_filter_cutoff_o inside {10'd250, 10'd500, 10'd750, 10'd1000})
    else $error("cutoff illegal");
  freeze_a: assert property (!clk_en_i |=> $stable(ripple_enable_o))
    else $error("state moved while frozen");
endmodule
bind rccfg_regs rccfg_props #(.COUNT_W(COUNT_W)) u_props (.clk_sys_i,
  .sys_rst_i, .clk_en_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i,
  .correction_pulse_off_i, .ripple_count_value_i, .reg_rvalid_o,
  .output_filter_cutoff_o, .external_duty_active_o, .external_duty_value_o,
  .speed_reg_active_o, .voltage_reg_active_o, .ripple_enable_o,
  .correction_module_on_o, .correction_pulse_on_o, .bridge_hiz_o,
  .threshold_reached_o, .ripple_threshold_eff_o);
`default_nettype wire

// ---- tb/rccfg_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module rccfg_host
  import rccfg_pkg::*;
(
  input  wire logic       clk_sys_i,
  input  wire logic [7:0] rdata_i,
  input  wire logic       rvalid_i,
  output logic [7:0]      addr_o = 8'h00,
  output logic            wr_o = 1'b0,
  output logic            rd_o = 1'b0,
  output logic [7:0]      wdata_o = 8'h00
);
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a == RCCFG_OFS_INV_RES && v == 8'h00) v = 8'h01;
    @(posedge clk_sys_i);
    addr_o <= a;
    wdata_o <= v;
    wr_o <= 1'b1;
    @(posedge clk_sys_i);
    wr_o <= 1'b0;
    // Released lines never keep the last value
    addr_o <= ~a;
    wdata_o <= ~v;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge clk_sys_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_sys_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    @(posedge clk_sys_i);
    d = rdata_i;
    v = rvalid_i;
  endtask
endmodule
`default_nettype wire

// ---- tb/test_ripple_count_config_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_ripple_count_config_regs
  import rccfg_pkg::*;
;
  logic        clk_sys_i = 1'b0, sys_rst_i = 1'b1, clk_en_i = 1'b1;
  logic        bridge_ctrl_select_i = 1'b1, duty_ctrl_select_i = 1'b0;
  logic        correction_pulse_off_i = 1'b0, reg_wr_i, reg_rd_i;
  logic [1:0]  reg_mode_i = RCCFG_MODE_FIXED;
  logic [16:0] ripple_count_value_i = 17'h00000, ripple_threshold_eff_o;
  logic [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o, backemf_value_o;
  logic [7:0]  inverse_resistance_value_o;
  logic        reg_rvalid_o, external_duty_active_o, speed_reg_active_o;
  logic        voltage_reg_active_o, ripple_enable_o, bridge_hiz_o;
  logic        correction_module_on_o, correction_pulse_on_o;
  logic        threshold_reached_o;
  logic [9:0]  output_filter_cutoff_o;
  logic [5:0]  external_duty_value_o;
  logic [4:0]  filter_input_gain_o;
  logic [2:0]  current_mirror_gain_o;
  logic [13:0] inverse_resistance_multiplier_o;
  logic [17:0] backemf_multiplier_o;
  int          miscompares = 0, tests_run = 0, cycles = 0;
  rccfg_regs DUT (.clk_sys_i, .sys_rst_i, .clk_en_i, .reg_addr_i, .reg_wr_i,
    .reg_rd_i, .reg_wdata_i, .bridge_ctrl_select_i, .duty_ctrl_select_i,
    .reg_mode_i, .correction_pulse_off_i, .ripple_count_value_i,
    .reg_rdata_o, .reg_rvalid_o, .output_filter_cutoff_o,
    .external_duty_active_o, .external_duty_value_o, .speed_reg_active_o,
    .voltage_reg_active_o, .ripple_enable_o, .correction_module_on_o,
    .correction_pulse_on_o, .bridge_hiz_o, .threshold_reached_o,
    .filter_input_gain_o, .current_mirror_gain_o, .ripple_threshold_eff_o,
    .inverse_resistance_multiplier_o, .backemf_multiplier_o,
    .inverse_resistance_value_o, .backemf_value_o);
  rccfg_host host (.clk_sys_i, .rdata_i(reg_rdata_o), .rvalid_i(reg_rvalid_o),
    .addr_o(reg_addr_i), .wr_o(reg_wr_i), .rd_o(reg_rd_i),
    .wdata_o(reg_wdata_i));
  initial begin
    forever #25 clk_sys_i = ~clk_sys_i;
  end
  task automatic print_verdict;
    if (miscompares == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Two-edge decode latency plus one edge of margin
  task automatic settle;
    repeat (3) @(posedge clk_sys_i);
  endtask
  task automatic t_regs;
    logic [7:0] rv [7] = '{8'h00, 8'h88, 8'hff, 8'h7f, 8'h00, 8'h00, 8'h00};
    logic [7:0] d;
    logic       v;
    settle();
    chk(ripple_threshold_eff_o, 18'h0ffc0);
    chk(backemf_multiplier_o, 18'(24 << 13));
    chk({ripple_enable_o, correction_module_on_o}, 18'h3);
    chk(output_filter_cutoff_o, 18'd250);
    for (int i = 0; i < 7; i++) begin
      host.rd(8'h10 + i[7:0], d, v);
      chk({v, d}, {1'b1, rv[i]});
      host.wr(8'h10 + i[7:0], 8'h5a ^ i[7:0]);
      host.rd(8'h10 + i[7:0], d, v);
      chk(d, i == 6 ? 8'h00 : 8'h5a ^ i[7:0]);
    end
  endtask
  task automatic t_codes;
    int m_thr [4] = '{2, 8, 16, 64};
    int m_inv [4] = '{2, 64, 1024, 8192};
    int s_bem [4] = '{8, 9, 12, 13};
    for (int i = 0; i < 4; i++) begin
      host.wr(RCCFG_OFS_FILTER_DUTY, {i[1:0], 6'h00});
      host.wr(RCCFG_OFS_SCALE_CTRL, {i[1:0], i[1:0], i[1:0], 2'b10});
      host.wr(RCCFG_OFS_RIPPLE_CTRL, {3'b100, i[1:0], 3'b000});
      host.wr(RCCFG_OFS_THR_LOW, 8'h03);
      settle();
      chk(output_filter_cutoff_o, 18'(250 * (i + 1)));
      chk(ripple_threshold_eff_o, 18'(515 * m_thr[i]));
      chk(inverse_resistance_multiplier_o, 18'(m_inv[i]));
      chk(backemf_multiplier_o, 18'(24 << s_bem[i]));
      chk(filter_input_gain_o, 18'(2 << i));
    end
    for (int i = 0; i < 8; i++) begin
      host.wr(RCCFG_OFS_RIPPLE_CTRL, 8'h80 | i[7:0]);
      settle();
      chk(current_mirror_gain_o, 18'(i < 4 ? 5 - i : 1 - i % 2));
    end
  endtask
  task automatic t_duty;
    host.wr(RCCFG_OFS_FILTER_DUTY, 8'h3f);
    // External duty wins over speed regulation while speed mode is asked for
    bridge_ctrl_select_i <= 1'b0;
    duty_ctrl_select_i <= 1'b1;
    reg_mode_i <= RCCFG_MODE_SPEED;
    settle();
    chk({external_duty_active_o, external_duty_value_o}, 7'h7f);
    chk({speed_reg_active_o, voltage_reg_active_o}, 2'b00);
    bridge_ctrl_select_i <= 1'b1;
    settle();
    chk({external_duty_active_o, external_duty_value_o}, 7'h00);
    chk(speed_reg_active_o, 1'b1);
    bridge_ctrl_select_i <= 1'b0;
    reg_mode_i <= RCCFG_MODE_VOLTAGE;
    host.wr(RCCFG_OFS_FILTER_DUTY, 8'h00);
    settle();
    chk({external_duty_active_o, voltage_reg_active_o,
         external_duty_value_o}, 8'h80);
    duty_ctrl_select_i <= 1'b0;
    settle();
    chk({external_duty_active_o, voltage_reg_active_o}, 2'b01);
  endtask
  task automatic t_thr;
    logic [7:0] d;
    logic       v;
    host.wr(RCCFG_OFS_THR_LOW, 8'h05);
    host.wr(RCCFG_OFS_SCALE_CTRL, 8'h00);
    host.wr(RCCFG_OFS_RIPPLE_CTRL, 8'ha0);
    host.wr(RCCFG_OFS_INV_RES, 8'h20);
    host.wr(RCCFG_OFS_BACKEMF, 8'ha3);
    ripple_count_value_i <= 17'd10;
    settle();
    chk({threshold_reached_o, bridge_hiz_o}, 2'b00);
    chk({inverse_resistance_value_o, backemf_value_o}, 16'h20a3);
    ripple_count_value_i <= 17'd11;
    settle();
    chk({threshold_reached_o, bridge_hiz_o}, 2'b11);
    host.wr(RCCFG_OFS_RIPPLE_CTRL, 8'hc0);
    correction_pulse_off_i <= 1'b1;
    settle();
    chk({bridge_hiz_o, correction_module_on_o}, 2'b00);
    host.wr(RCCFG_OFS_RIPPLE_CTRL, 8'h80);
    settle();
    chk({correction_module_on_o, correction_pulse_on_o}, 2'b10);
    correction_pulse_off_i <= 1'b0;
    clk_en_i <= 1'b0;
    host.wr(RCCFG_OFS_THR_LOW, 8'h77);
    clk_en_i <= 1'b1;
    host.rd(RCCFG_OFS_THR_LOW, d, v);
    chk({correction_pulse_on_o, d}, 9'h105);
  endtask
  always @(posedge clk_sys_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      print_verdict();
    end
  end
  initial begin
    repeat (10) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    t_regs();
    t_codes();
    t_duty();
    t_thr();
    print_verdict();
  end
endmodule
`default_nettype wire
